// ### tslir_pkg.sv
package tslir_pkg;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned PTR_W = 4;
    localparam logic [PTR_W-1:0] REG_UPPER_LIMIT = 4'h3;
    localparam logic [PTR_W-1:0] REG_PART_IDENTITY = 4'hF;
    localparam logic [15:0] UPPER_LIMIT_RESET = 16'h5000;
    localparam logic [15:0] LIMIT_FIELD_MASK = 16'hFFF0;
    // arbitrary value, not tied to any real part
    localparam logic [15:0] PART_IDENTITY_DEFAULT = 16'hA500;
    localparam logic [ADDR_W-1:0] TARGET_BASE_FULL = 7'h40;
    localparam logic [ADDR_W-1:0] TARGET_BASE_REDUCED = 7'h48;
    localparam int unsigned ADDR_SEL_FULL = 5;
    localparam int unsigned ADDR_SEL_REDUCED = 2;
    typedef enum logic [6:0] {
        TSLIR_IDLE = 7'b000_0001,
        TSLIR_ADDR = 7'b000_0010,
        TSLIR_AACK = 7'b000_0100,
        TSLIR_WBYTE = 7'b000_1000,
        TSLIR_WACK = 7'b001_0000,
        TSLIR_RBYTE = 7'b010_0000,
        TSLIR_RACK = 7'b100_0000
    } tslir_state_e;
endpackage

// ### tslir_regs.sv
// Operation
// - upper limit keeps bits 15:4, low nibble zero
// - address 0Fh is read-only identity register
// - identity exists only on standard variant
// - identity is sixteen constant bits
// - one- or two-byte transfers, chosen per transaction
// - 32 target addresses standard, 4 reduced
// - single byte writes/reads use bits 15:8
// - upper limit at 03h, resets to 5000h
module tslir_regs
    import tslir_pkg::*;
#(
    parameter bit REDUCED_VARIANT = 1'b0,
    parameter logic [15:0] PART_IDENTITY_VALUE = PART_IDENTITY_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [4:0] addr_strap,
    output logic sda_out,
    output logic sda_oe_n,
    output logic [15:0] upper_temp_limit
);
    logic [2:0] scl_s, sda_s;
    tslir_state_e state, next_state;
    logic [7:0] shreg, next_shreg;
    logic [3:0] bitcnt, next_bitcnt;
    logic [PTR_W-1:0] ptr, next_ptr;
    logic [15:0] limit, next_limit;
    logic [7:0] hold, next_hold;
    logic [1:0] bytecnt, next_bytecnt;
    logic rw, next_rw;
    logic drive_low, next_drive_low;
    logic [4:0] strap, next_strap;
    logic [4:0] strap_s;
    logic [ADDR_W-1:0] my_addr;
    logic [15:0] rd_word;
    logic scl_rise, scl_fall, start_c, stop_c;

    // two-flop sync; only the second and third stages feed logic
    // strap pins: first stage here, second is strap, loaded while idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s <= 3'b111;
            sda_s <= 3'b111;
            strap_s <= 5'h00;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            strap_s <= addr_strap;
        end
    end
    assign scl_rise = scl_s[1] & ~scl_s[2];
    assign scl_fall = ~scl_s[1] & scl_s[2];
    assign start_c = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
    assign stop_c = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

    always_comb begin
        if (REDUCED_VARIANT) begin
            my_addr = TARGET_BASE_REDUCED | ADDR_W'(strap[ADDR_SEL_REDUCED-1:0]);
        end else begin
            my_addr = TARGET_BASE_FULL | ADDR_W'(strap[ADDR_SEL_FULL-1:0]);
        end
        unique case (ptr)
            REG_UPPER_LIMIT: rd_word = limit;
            REG_PART_IDENTITY: rd_word = REDUCED_VARIANT ? 16'h0000 : PART_IDENTITY_VALUE;
            default: rd_word = 16'h0000;
        endcase
    end

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_ptr = ptr;
        next_limit = limit;
        next_hold = hold;
        next_bytecnt = bytecnt;
        next_rw = rw;
        next_drive_low = drive_low;
        next_strap = strap;
        if (state == TSLIR_IDLE) begin
            next_strap = strap_s;
        end
        if (stop_c) begin
            // a lone high byte commits on stop: legacy one-byte write
            if (state != TSLIR_IDLE && !rw && bytecnt == 2'd2
                    && ptr == REG_UPPER_LIMIT) begin
                next_limit = {hold, limit[7:0]} & LIMIT_FIELD_MASK;
            end
            next_state = TSLIR_IDLE;
            next_drive_low = 1'b0;
        end else if (start_c) begin
            next_state = TSLIR_ADDR;
            next_bitcnt = 4'd0;
            next_bytecnt = 2'd0;
            next_drive_low = 1'b0;
        end else begin
            unique case (state)
                TSLIR_IDLE: ;
                TSLIR_ADDR: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_s[1]};
                        next_bitcnt = bitcnt + 4'd1;
                    end
                    if (scl_fall && bitcnt == 4'd8) begin
                        if (shreg[7:1] == my_addr) begin
                            next_rw = shreg[0];
                            next_drive_low = 1'b1;
                            next_state = TSLIR_AACK;
                        end else begin
                            next_state = TSLIR_IDLE;
                        end
                    end
                end
                TSLIR_AACK: begin
                    if (scl_fall) begin
                        next_bitcnt = 4'd0;
                        if (rw) begin
                            next_shreg = rd_word[15:8];
                            next_drive_low = ~rd_word[15];
                            next_state = TSLIR_RBYTE;
                        end else begin
                            next_drive_low = 1'b0;
                            next_state = TSLIR_WBYTE;
                        end
                    end
                end
                TSLIR_WBYTE: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_s[1]};
                        next_bitcnt = bitcnt + 4'd1;
                    end
                    if (scl_fall && bitcnt == 4'd8) begin
                        next_drive_low = 1'b1;
                        next_state = TSLIR_WACK;
                        if (bytecnt == 2'd0) begin
                            next_ptr = shreg[PTR_W-1:0];
                        end else if (bytecnt == 2'd1) begin
                            next_hold = shreg;
                        end else if (ptr == REG_UPPER_LIMIT) begin
                            // writes to identity fall through here unused
                            next_limit = {hold, shreg} & LIMIT_FIELD_MASK;
                        end
                        if (bytecnt != 2'd3) begin
                            next_bytecnt = bytecnt + 2'd1;
                        end
                    end
                end
                TSLIR_WACK: begin
                    if (scl_fall) begin
                        next_drive_low = 1'b0;
                        next_bitcnt = 4'd0;
                        next_state = TSLIR_WBYTE;
                    end
                end
                TSLIR_RBYTE: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'd7) begin
                            next_drive_low = 1'b0;
                            next_state = TSLIR_RACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_drive_low = ~shreg[6];
                            next_bitcnt = bitcnt + 4'd1;
                        end
                    end
                end
                TSLIR_RACK: begin
                    // host nack ends the read: one byte or two, its choice
                    if (scl_rise && sda_s[1]) begin
                        next_state = TSLIR_IDLE;
                    end else if (scl_fall) begin
                        next_bitcnt = 4'd0;
                        next_shreg = rd_word[7:0];
                        next_drive_low = ~rd_word[7];
                        next_state = TSLIR_RBYTE;
                    end
                end
                default: next_state = TSLIR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= TSLIR_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'd0;
            ptr <= '0;
            limit <= UPPER_LIMIT_RESET;
            hold <= 8'h00;
            bytecnt <= 2'd0;
            rw <= 1'b0;
            drive_low <= 1'b0;
            strap <= 5'd0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            ptr <= next_ptr;
            limit <= next_limit;
            hold <= next_hold;
            bytecnt <= next_bytecnt;
            rw <= next_rw;
            drive_low <= next_drive_low;
            strap <= next_strap;
        end
    end

    // open drain: only ever pull low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b1;
            sda_oe_n <= 1'b1;
            upper_temp_limit <= UPPER_LIMIT_RESET;
        end else begin
            sda_out <= 1'b0;
            sda_oe_n <= ~next_drive_low;
            upper_temp_limit <= next_limit;
        end
    end
endmodule

// ### tslir_regs_monitor.sv
module tslir_regs_monitor
    import tslir_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [4:0] addr_strap,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [15:0] upper_temp_limit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_nibble;
        upper_temp_limit[3:0] == 4'h0;
    endproperty
    a_nibble: assert property (p_nibble) else $error("limit low nibble set");
    property p_reset_val;
        $rose(rst_n) |-> upper_temp_limit == UPPER_LIMIT_RESET;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("limit reset value wrong");
    property p_pull_low;
        !sda_oe_n |-> !sda_out;
    endproperty
    a_pull_low: assert property (p_pull_low) else $error("sda driven high");
    // bits may only move while the clock line has been low a while
    property p_sda_moves;
        $changed(sda_oe_n) |-> !scl_in && $past(scl_in, 2) == 1'b0;
    endproperty
    a_sda_moves: assert property (p_sda_moves) else $error("sda moved with scl high");
    // a bit driven by the device must stand through the whole high phase
    property p_sda_holds;
        scl_in && $past(scl_in) |-> $stable(sda_oe_n);
    endproperty
    a_sda_holds: assert property (p_sda_holds) else $error("sda drive changed in high phase");
    property p_commit;
        $changed(upper_temp_limit) |-> $past(sda_oe_n);
    endproperty
    a_commit: assert property (p_commit) else $error("limit changed during ack");
endmodule

bind tslir_regs tslir_regs_monitor u_tslir_regs_monitor (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .addr_strap(addr_strap), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .upper_temp_limit(upper_temp_limit)
);

// ### tslir_host_model.sv
module tslir_host_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic tick();
        repeat (6) @(negedge clk);
    endtask
    task automatic start();
        sda = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda = 1'b0;
        tick();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda = 1'b1;
        tick();
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda = b;
        tick();
        scl = 1'b1;
        tick();
        r = sda_line;
        scl = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(nack, r);
    endtask
endmodule

// ### tslir_regs_test.sv
module tslir_regs_test
    import tslir_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, scl, sda, sda_out, sda_oe_n, ack, k;
    logic [4:0] strap;
    logic [15:0] limit, d;
    logic [6:0] dev;
    logic [4:0] straps [3] = '{5'h15, 5'h00, 5'h1f};
    wire sda_line = sda & (sda_oe_n | sda_out);
    int errors = 0;
    int checked = 0;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    tslir_host_model u_tslir_host_model (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda));
    tslir_regs u_tslir_regs (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .addr_strap(strap), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .upper_temp_limit(limit));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] p, input logic [15:0] v, input int n);
        u_tslir_host_model.start();
        u_tslir_host_model.send_byte({dev, 1'b0}, ack);
        u_tslir_host_model.send_byte({4'h0, p}, k);
        if (n > 0) u_tslir_host_model.send_byte(v[15:8], k);
        if (n > 1) u_tslir_host_model.send_byte(v[7:0], k);
        u_tslir_host_model.stop();
    endtask
    task automatic rd(input logic [3:0] p, input int n);
        d = 16'h0000;
        wr(p, 16'h0000, 0);
        u_tslir_host_model.start();
        u_tslir_host_model.send_byte({dev, 1'b1}, k);
        u_tslir_host_model.recv_byte(n == 1, d[15:8]);
        if (n > 1) u_tslir_host_model.recv_byte(1'b1, d[7:0]);
        u_tslir_host_model.stop();
    endtask
    initial begin
        // the whole run needs about 7000 cycles
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        strap = 5'h15;
        dev = TARGET_BASE_FULL | 7'h15;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("limit port", 16'h5000, limit);
        rd(4'h3, 2);
        chk("limit read", 16'h5000, d);
        $display("test reset done");
        wr(4'h3, 16'h5a3f, 2);
        chk("limit port", 16'h5a30, limit);
        rd(4'h3, 2);
        chk("two byte read", 16'h5a30, d);
        wr(4'hc, 16'h1230, 2);
        chk("limit kept", 16'h5a30, limit);
        wr(4'h3, 16'hc7ff, 1);
        rd(4'h3, 2);
        chk("one byte write", 16'hc730, d);
        rd(4'h3, 1);
        chk("one byte read", 16'hc700, d);
        $display("test limit done");
        wr(4'hf, 16'h1234, 2);
        rd(4'hf, 2);
        chk("identity", PART_IDENTITY_DEFAULT, d);
        rd(4'hf, 1);
        chk("identity high", {PART_IDENTITY_DEFAULT[15:8], 8'h00}, d);
        chk("limit kept", 16'hc730, limit);
        $display("test identity done");
        for (int i = 0; i < 3; i++) begin
            strap = straps[i];
            dev = TARGET_BASE_FULL | {2'b00, strap};
            wr(4'h3, 16'h0000, 0);
            chk("own address ack", 16'h0001, {15'h0000, ack});
            dev = dev ^ 7'h01;
            wr(4'h3, 16'h0000, 0);
            chk("other address ack", 16'h0000, {15'h0000, ack});
        end
        $display("test address done");
        complete_run();
    end
endmodule
